// ### core/atb_pkg.sv
`default_nettype none

package atb_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_EVGEN = 8'h0c;
  localparam logic [7:0] OFF_COUNT = 8'h10;
  localparam logic [7:0] OFF_RATIO = 8'h14;
  localparam logic [7:0] OFF_RELOAD = 8'h18;
  localparam logic [7:0] OFF_REPEAT = 8'h1c;

  localparam int CTRL_CEN_BIT = 0;
  localparam int CTRL_UPDATE_DISABLE_BIT = 1;
  localparam int CTRL_URS_BIT = 2;
  localparam int CTRL_RELOAD_BUFFER_ENABLE_BIT = 7;
  localparam int STATUS_UIF_BIT = 0;
  localparam int MASK_UIE_BIT = 0;
  localparam int EVGEN_UG_BIT = 0;

  localparam logic [31:0] RST_RELOAD = 32'h0000ffff;
  localparam logic [31:0] RST_ZERO = 32'h00000000;

  localparam int CEN_START_CYC = 1;

endpackage : atb_pkg

`default_nettype wire

// ### core/atb_prescaler.sv
`default_nettype none

module atb_prescaler #(
  parameter int PSC_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic run_i,
  input wire logic restart_i,
  input wire logic load_i,
  input wire logic [PSC_W-1:0] ratio_i,
  output logic tick_o
);

  typedef struct packed {
    logic [PSC_W-1:0] cnt;
    logic [PSC_W-1:0] ratio_act;
  } atb_psc_state_t;

  atb_psc_state_t state;
  atb_psc_state_t next_state;

  // Gated output tick, every ratio plus one clocks
  assign tick_o = run_i && (state.cnt == state.ratio_act);

  always_comb begin
    next_state = state;
    if (restart_i) begin
      next_state.cnt = '0;
    end else if (run_i) begin
      next_state.cnt = tick_o ? '0 : state.cnt + 1'b1;
    end
    if (load_i) begin
      next_state.ratio_act = ratio_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_tick_spacing;
    tick_o && !restart_i && !load_i && (state.ratio_act != '0) |=> !tick_o;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("prescaler ticked twice");

endmodule : atb_prescaler

`default_nettype wire

// ### core/atb_rep_counter.sv
`default_nettype none

module atb_rep_counter #(
  parameter int REP_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ovf_i,
  input wire logic reload_i,
  input wire logic [REP_W-1:0] rcr_i,
  output logic hit_o
);

  typedef struct packed {
    logic [REP_W-1:0] cnt;
  } atb_rep_state_t;

  atb_rep_state_t state;
  atb_rep_state_t next_state;

  // Overflow that finds the count at zero
  assign hit_o = ovf_i && (state.cnt == '0);

  always_comb begin
    next_state = state;
    if (reload_i || hit_o) begin
      next_state.cnt = rcr_i;
    end else if (ovf_i) begin
      next_state.cnt = state.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_rep_decrement;
    ovf_i && !reload_i && (state.cnt != '0) |=> state.cnt == $past(state.cnt) - 1'b1;
  endproperty
  a_rep_decrement: assert property (p_rep_decrement) else $error("repetition not counted");

endmodule : atb_rep_counter

`default_nettype wire

// ### core/atb_time_base.sv
`default_nettype none

module atb_time_base #(
  parameter int CNT_W = 16,
  parameter int PSC_W = 16,
  parameter int REP_W = 8
) (
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic SLV_UG_I,
  output logic [31:0] RDATA_O,
  output logic IRQ_O,
  output logic UEV_O,
  output logic OVF_O
);

  typedef struct packed {
    logic counter_enable_bit;
    logic update_disable;
    logic update_request_select;
    logic reload_buffer_enable;
    logic update_flag;
    logic uie;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] arr_pre;
    logic [CNT_W-1:0] arr_sh;
    logic [PSC_W-1:0] psc_pre;
    logic [REP_W-1:0] repetition_count_reg;
    logic update_event;
    logic ovf;
    logic [31:0] rdata;
  } atb_state_t;

  atb_state_t state;
  atb_state_t next_state;

  function automatic logic wr_hit(
    input logic [7:0] addr,
    input logic wr,
    input logic [7:0] off
  );
    return wr && (addr == off);
  endfunction : wr_hit

  logic ctrl_wr;
  logic status_wr;
  logic mask_wr;
  logic evgen_wr;
  logic cnt_wr;
  logic ratio_wr;
  logic reload_wr;
  logic repeat_wr;
  logic ug;
  logic tick;
  logic wrap;
  logic rep_hit;
  logic ovf_uev;
  logic update_event;
  logic set_uif;
  logic [CNT_W-1:0] arr_act;

  assign ctrl_wr = wr_hit(ADDR_I, WR_I, atb_pkg::OFF_CTRL);
  assign status_wr = wr_hit(ADDR_I, WR_I, atb_pkg::OFF_STATUS);
  assign mask_wr = wr_hit(ADDR_I, WR_I, atb_pkg::OFF_MASK);
  assign evgen_wr = wr_hit(ADDR_I, WR_I, atb_pkg::OFF_EVGEN);
  assign cnt_wr = wr_hit(ADDR_I, WR_I, atb_pkg::OFF_COUNT);
  assign ratio_wr = wr_hit(ADDR_I, WR_I, atb_pkg::OFF_RATIO);
  assign reload_wr = wr_hit(ADDR_I, WR_I, atb_pkg::OFF_RELOAD);
  assign repeat_wr = wr_hit(ADDR_I, WR_I, atb_pkg::OFF_REPEAT);

  // Forced update request, software or slave controller
  assign ug = (evgen_wr && WDATA_I[atb_pkg::EVGEN_UG_BIT]) || SLV_UG_I;

  // Compare value: preload when unbuffered, shadow otherwise
  assign arr_act = state.reload_buffer_enable ? state.arr_sh : state.arr_pre;

  // Wrap at or past the compare value
  assign wrap = tick && (state.cnt >= arr_act);

  // Overflow update only while enabled
  assign ovf_uev = rep_hit && !state.update_disable;
  assign update_event = ovf_uev || (ug && !state.update_disable);
  assign set_uif = ovf_uev || (ug && !state.update_disable && !state.update_request_select);

  atb_prescaler #(
    .PSC_W(PSC_W)
  ) u_prescaler (
    .clk_i(CLOCK_I),
    .rst_b_i(RST_B_I),
    .run_i(state.counter_enable_bit),
    .restart_i(ug),
    .load_i(update_event),
    .ratio_i(state.psc_pre),
    .tick_o(tick)
  );

  atb_rep_counter #(
    .REP_W(REP_W)
  ) u_rep_counter (
    .clk_i(CLOCK_I),
    .rst_b_i(RST_B_I),
    .ovf_i(wrap),
    .reload_i(ug),
    .rcr_i(state.repetition_count_reg),
    .hit_o(rep_hit)
  );

  always_comb begin
    next_state = state;
    next_state.update_event = update_event;
    next_state.ovf = wrap;
    // Control bits
    if (ctrl_wr) begin
      next_state.counter_enable_bit = WDATA_I[atb_pkg::CTRL_CEN_BIT];
      next_state.update_disable = WDATA_I[atb_pkg::CTRL_UPDATE_DISABLE_BIT];
      next_state.update_request_select = WDATA_I[atb_pkg::CTRL_URS_BIT];
      next_state.reload_buffer_enable = WDATA_I[atb_pkg::CTRL_RELOAD_BUFFER_ENABLE_BIT];
    end
    if (mask_wr) begin
      next_state.uie = WDATA_I[atb_pkg::MASK_UIE_BIT];
    end
    // Counter: write, forced restart, wrap, or step
    if (cnt_wr) begin
      next_state.cnt = WDATA_I[CNT_W-1:0];
    end else if (ug) begin
      next_state.cnt = '0;
    end else if (wrap) begin
      next_state.cnt = '0;
    end else if (tick) begin
      next_state.cnt = state.cnt + 1'b1;
    end
    // Preload registers
    if (ratio_wr) begin
      next_state.psc_pre = WDATA_I[PSC_W-1:0];
    end
    if (reload_wr) begin
      next_state.arr_pre = WDATA_I[CNT_W-1:0];
    end
    if (repeat_wr) begin
      next_state.repetition_count_reg = WDATA_I[REP_W-1:0];
    end
    // Shadow copy of reload value
    if (!state.reload_buffer_enable) begin
      next_state.arr_sh = next_state.arr_pre;
    end else if (update_event) begin
      next_state.arr_sh = state.arr_pre;
    end
    // Sticky flag, set beats clear
    if (status_wr && WDATA_I[atb_pkg::STATUS_UIF_BIT]) begin
      next_state.update_flag = 1'b0;
    end
    if (set_uif) begin
      next_state.update_flag = 1'b1;
    end
    // Read data, valid one cycle after strobe
    next_state.rdata = '0;
    if (RD_I) begin
      if (ADDR_I == atb_pkg::OFF_CTRL) begin
        next_state.rdata[atb_pkg::CTRL_CEN_BIT] = state.counter_enable_bit;
        next_state.rdata[atb_pkg::CTRL_UPDATE_DISABLE_BIT] = state.update_disable;
        next_state.rdata[atb_pkg::CTRL_URS_BIT] = state.update_request_select;
        next_state.rdata[atb_pkg::CTRL_RELOAD_BUFFER_ENABLE_BIT] = state.reload_buffer_enable;
      end else if (ADDR_I == atb_pkg::OFF_STATUS) begin
        next_state.rdata[atb_pkg::STATUS_UIF_BIT] = state.update_flag;
      end else if (ADDR_I == atb_pkg::OFF_MASK) begin
        next_state.rdata[atb_pkg::MASK_UIE_BIT] = state.uie;
      end else if (ADDR_I == atb_pkg::OFF_COUNT) begin
        next_state.rdata = 32'(state.cnt);
      end else if (ADDR_I == atb_pkg::OFF_RATIO) begin
        next_state.rdata = 32'(state.psc_pre);
      end else if (ADDR_I == atb_pkg::OFF_RELOAD) begin
        next_state.rdata = 32'(state.arr_pre);
      end else if (ADDR_I == atb_pkg::OFF_REPEAT) begin
        next_state.rdata = 32'(state.repetition_count_reg);
      end else begin
        next_state.rdata = '0;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      state <= '0;
      state.arr_pre <= CNT_W'(atb_pkg::RST_RELOAD);
      state.arr_sh <= CNT_W'(atb_pkg::RST_RELOAD);
      state.rdata <= atb_pkg::RST_ZERO;
    end else begin
      state <= next_state;
    end
  end

  assign RDATA_O = state.rdata;
  assign IRQ_O = state.update_flag && state.uie;
  assign UEV_O = state.update_event;
  assign OVF_O = state.ovf;

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_B_I);

  // Counter holds while disabled
  property p_hold_when_off;
    !state.counter_enable_bit && !cnt_wr && !ug |=> $stable(state.cnt);
  endproperty
  a_hold_when_off: assert property (p_hold_when_off) else $error("count moved while off");

  // Enable write does not count in the next cycle
  property p_start_delay;
    ctrl_wr && WDATA_I[atb_pkg::CTRL_CEN_BIT] && !state.counter_enable_bit && !SLV_UG_I
      |=> $stable(state.cnt) && state.counter_enable_bit
        && (tick || (u_prescaler.state.cnt != u_prescaler.state.ratio_act));
  endproperty
  a_start_delay: assert property (p_start_delay) else $error("start latency wrong");

  // Wrap to zero with overflow pulse
  property p_wrap_zero;
    wrap && !cnt_wr && !ug |=> (state.cnt == '0) && OVF_O;
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) else $error("wrap not to zero");

  // Single step on each tick
  property p_step;
    tick && !wrap && !cnt_wr && !ug |=> state.cnt == $past(state.cnt) + 1'b1;
  endproperty
  a_step: assert property (p_step) else $error("count did not step");

  // Never above the active reload while running freely
  property p_bounded;
    state.counter_enable_bit && !cnt_wr && !ug && !reload_wr && (state.cnt <= arr_act) && !ctrl_wr
      |=> state.cnt <= $past(arr_act);
  endproperty
  a_bounded: assert property (p_bounded) else $error("count passed reload");

  // Disabled updates stay silent
  property p_update_disable_block;
    state.update_disable |=> !UEV_O;
  endproperty
  a_update_disable_block: assert property (p_update_disable_block) else $error("update while disabled");

  // Overflow with repetition hit updates and flags
  property p_ovf_update;
    rep_hit && !state.update_disable |=> UEV_O && state.update_flag;
  endproperty
  a_ovf_update: assert property (p_ovf_update) else $error("overflow update missed");

  // Overflow not at repetition zero gives no update
  property p_rep_thin;
    wrap && !rep_hit && !ug |=> !UEV_O;
  endproperty
  a_rep_thin: assert property (p_rep_thin) else $error("update not thinned");

  // Slave forced update
  property p_slave_ug;
    SLV_UG_I && !state.update_disable |=> UEV_O;
  endproperty
  a_slave_ug: assert property (p_slave_ug) else $error("slave update lost");

  // Forced update restarts the counter
  property p_ug_restart;
    ug && !cnt_wr |=> state.cnt == '0;
  endproperty
  a_ug_restart: assert property (p_ug_restart) else $error("no restart on update");

  // Request select keeps flag clear on forced update
  property p_urs_quiet;
    ug && state.update_request_select && !state.update_disable && !ovf_uev && !state.update_flag |=> UEV_O && !state.update_flag;
  endproperty
  a_urs_quiet: assert property (p_urs_quiet) else $error("flag set by forced update");

  // Buffered reload write reaches preload only
  property p_arr_preload;
    reload_wr && state.reload_buffer_enable && !update_event
      |=> (state.arr_pre == $past(WDATA_I[CNT_W-1:0])) && $stable(state.arr_sh);
  endproperty
  a_arr_preload: assert property (p_arr_preload) else $error("shadow written directly");

  // Buffered transfer at update
  property p_arr_transfer;
    update_event && state.reload_buffer_enable |=> state.arr_sh == $past(state.arr_pre);
  endproperty
  a_arr_transfer: assert property (p_arr_transfer) else $error("shadow not loaded");

  // Count register read back
  property p_cnt_read;
    RD_I && (ADDR_I == atb_pkg::OFF_COUNT) |=> RDATA_O == 32'($past(state.cnt));
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("count read wrong");

  // Flag set wins over clear
  property p_set_wins;
    set_uif && status_wr |=> state.update_flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag lost on clear");

  // Unbuffered reload write reaches the shadow at once
  property p_unbuf_follow;
    reload_wr && !state.reload_buffer_enable |=> state.arr_sh == $past(WDATA_I[CNT_W-1:0]);
  endproperty
  a_unbuf_follow: assert property (p_unbuf_follow) else $error("shadow not following");

  // Count write loads the counter
  property p_cnt_write;
    cnt_wr |=> state.cnt == $past(WDATA_I[CNT_W-1:0]);
  endproperty
  a_cnt_write: assert property (p_cnt_write) else $error("count write lost");

  // Flag cleared by a one when no set
  property p_uif_clear;
    status_wr && WDATA_I[atb_pkg::STATUS_UIF_BIT] && !set_uif |=> !state.update_flag;
  endproperty
  a_uif_clear: assert property (p_uif_clear) else $error("flag not cleared");

  // Flag sticky until cleared
  property p_uif_hold;
    state.update_flag && !status_wr |=> state.update_flag;
  endproperty
  a_uif_hold: assert property (p_uif_hold) else $error("flag dropped");

  // Read data zero outside the answer cycle
  property p_rdata_idle;
    !RD_I |=> RDATA_O == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  // Control write lands in the disable bit
  property p_update_disable_write;
    ctrl_wr |=> state.update_disable == $past(WDATA_I[atb_pkg::CTRL_UPDATE_DISABLE_BIT]);
  endproperty
  a_update_disable_write: assert property (p_update_disable_write) else $error("disable bit not written");

  c_wrap: cover property (wrap && !rep_hit);
  c_rep_update: cover property (ovf_uev);
  c_urs_ug: cover property (ug && state.update_request_select && !state.update_disable);
  c_update_disable_ovf: cover property (rep_hit && state.update_disable);
  c_reload_buffer_enable_update: cover property (update_event && state.reload_buffer_enable);

endmodule : atb_time_base

`default_nettype wire

// ### tb/atb_time_base_tb_top.sv
`default_nettype none
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin error_cnt++; \
  $display("unexpected %s expected %h seen %h", nm, e, s); end end

module atb_time_base_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk;
  logic rst_b;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr_s;
  logic rd_s;
  logic slv_ug;
  logic [31:0] rdata;
  logic irq;
  logic update_event;
  logic ovf;
  logic rd_d;
  logic [31:0] e_v;
  string n_v;
  int error_cnt;
  int checks;
  int uev_n;
  int ovf_n;
  logic [31:0] exp_q[$];
  string nm_q[$];

  atb_time_base dut (
    .CLOCK_I(clk),
    .RST_B_I(rst_b),
    .ADDR_I(addr),
    .WDATA_I(wdata),
    .WR_I(wr_s),
    .RD_I(rd_s),
    .SLV_UG_I(slv_ug),
    .RDATA_O(rdata),
    .IRQ_O(irq),
    .UEV_O(update_event),
    .OVF_O(ovf)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Pulse counters
  always @(negedge clk) begin
    if (update_event === 1'b1) uev_n++;
    if (ovf === 1'b1) ovf_n++;
  end

  // Read data checker
  always @(posedge clk) begin
    if (rd_d === 1'b1) begin
      e_v = exp_q.pop_front();
      n_v = nm_q.pop_front();
      `CHK(n_v, e_v, rdata)
    end
    rd_d <= rd_s;
  end

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    rd_s <= 1'b0;
    @(posedge clk);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e, input string n);
    addr <= a;
    rd_s <= 1'b1;
    wr_s <= 1'b0;
    exp_q.push_back(e);
    nm_q.push_back(n);
    @(posedge clk);
  endtask : reg_rd

  task automatic idle(input int n);
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic window(input int n, input int eo, input int eu);
    int o0;
    int u0;
    o0 = ovf_n;
    u0 = uev_n;
    idle(n);
    `CHK("overflows", eo, ovf_n - o0)
    `CHK("updates", eu, uev_n - u0)
  endtask : window

  task end_of_test;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    logic [7:0] a;
    logic [31:0] r;
    int u;
    int k;
    rst_b = 1'b0;
    addr = 8'h00;
    wdata = 32'h00000000;
    wr_s = 1'b0;
    rd_s = 1'b0;
    slv_ug = 1'b0;
    rd_d = 1'b0;
    error_cnt = 0;
    checks = 0;
    uev_n = 0;
    ovf_n = 0;
    void'($urandom(32'hf6c2));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values, unmapped place last
    for (int i = 0; i < 9; i++) begin
      a = (i == 8) ? 8'h40 : 8'(i * 4);
      r = (a == atb_pkg::OFF_RELOAD) ? atb_pkg::RST_RELOAD : atb_pkg::RST_ZERO;
      reg_rd(a, r, "reset");
    end
    for (int i = 0; i < 4; i++) begin
      r = $urandom();
      reg_wr(atb_pkg::OFF_RATIO, r);
      reg_wr(atb_pkg::OFF_RELOAD, r ^ 32'h00005a5a);
      reg_wr(atb_pkg::OFF_REPEAT, r);
      reg_wr(atb_pkg::OFF_COUNT, r);
      reg_rd(atb_pkg::OFF_RATIO, r & 32'h0000ffff, "ratio");
      reg_rd(atb_pkg::OFF_RELOAD, (r ^ 32'h00005a5a) & 32'h0000ffff, "reload");
      reg_rd(atb_pkg::OFF_REPEAT, r & 32'h000000ff, "repeat");
      reg_rd(atb_pkg::OFF_COUNT, r & 32'h0000ffff, "count");
    end
    // Forced update, flag and interrupt, then counting
    reg_wr(atb_pkg::OFF_RELOAD, 32'h3);
    reg_wr(atb_pkg::OFF_RATIO, 32'h0);
    reg_wr(atb_pkg::OFF_REPEAT, 32'h2);
    reg_wr(atb_pkg::OFF_MASK, 32'h1);
    reg_wr(atb_pkg::OFF_EVGEN, 32'h1);
    reg_rd(atb_pkg::OFF_STATUS, 32'h1, "flag");
    idle(1);
    `CHK("irq", 1'b1, irq)
    reg_wr(atb_pkg::OFF_STATUS, 32'h1);
    reg_rd(atb_pkg::OFF_STATUS, 32'h0, "flag clear");
    idle(1);
    `CHK("irq", 1'b0, irq)
    reg_wr(atb_pkg::OFF_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) reg_rd(atb_pkg::OFF_COUNT, i, "count run");
    window(48, 12, 4);
    // Updates blocked, preload only
    reg_wr(atb_pkg::OFF_REPEAT, 32'h0);
    reg_wr(atb_pkg::OFF_CTRL, 32'h83);
    reg_wr(atb_pkg::OFF_RATIO, 32'h3);
    reg_wr(atb_pkg::OFF_RELOAD, 32'h7);
    reg_rd(atb_pkg::OFF_RELOAD, 32'h7, "reload preload");
    window(32, 8, 0);
    // Updates allowed again: new ratio and reload take hold
    reg_wr(atb_pkg::OFF_CTRL, 32'h81);
    idle(0);
    for (k = 0; k < 100 && update_event !== 1'b1; k++) @(posedge clk);
    `CHK("update wait", 1'b1, update_event)
    window(80, 2, 2);
    // Quiet forced update, then slave request
    reg_wr(atb_pkg::OFF_CTRL, 32'h4);
    reg_wr(atb_pkg::OFF_STATUS, 32'h1);
    reg_wr(atb_pkg::OFF_COUNT, 32'h5);
    reg_rd(atb_pkg::OFF_COUNT, 32'h5, "count write");
    u = uev_n;
    reg_wr(atb_pkg::OFF_EVGEN, 32'h1);
    reg_rd(atb_pkg::OFF_STATUS, 32'h0, "flag quiet");
    reg_rd(atb_pkg::OFF_COUNT, 32'h0, "count restart");
    reg_wr(atb_pkg::OFF_CTRL, 32'h0);
    slv_ug <= 1'b1;
    idle(1);
    slv_ug <= 1'b0;
    reg_rd(atb_pkg::OFF_STATUS, 32'h1, "slave flag");
    idle(2);
    `CHK("forced updates", u + 2, uev_n)
    `CHK("irq", 1'b1, irq)
    reg_wr(atb_pkg::OFF_MASK, 32'h0);
    idle(2);
    `CHK("irq masked", 1'b0, irq)
    end_of_test();
  end

endmodule : atb_time_base_tb_top

`undef CHK
`default_nettype wire
